//--- fcsm_pkg.sv
// constants, types and command codes of the flash command sequencer host
package fcsm_pkg;
    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam int READY_BIT_POS = 7;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_NS = 8;
    localparam int T_WP_NS = 60;
    localparam int T_WPH_NS = 10;
    localparam int T_READ_NS = 80;
    localparam int SYNC_CYCLES = 2;
    localparam int WP_CYCLES = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYCLES = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYCLES = (T_READ_NS + CLK_NS - 1) / CLK_NS
        + SYNC_CYCLES;
    localparam int CNT_W = 5;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        OP_READ = 4'h0, OP_READ_ARRAY = 4'h1, OP_PROGRAM = 4'h2,
        OP_ERASE = 4'h3, OP_SUSPEND = 4'h4, OP_RESUME = 4'h5,
        OP_READ_STATUS = 4'h6, OP_CLEAR_STATUS = 4'h7,
        OP_READ_ID = 4'h8, OP_POLL = 4'h9
    } fcsm_op_type;

    typedef enum logic [3:0] {
        DEV_ARRAY = 4'h0, DEV_PROG_SETUP = 4'h1, DEV_PROG_BUSY = 4'h3,
        DEV_PROG_DONE = 4'h2, DEV_ERASE_SETUP = 4'h6,
        DEV_ERASE_ERR = 4'h7, DEV_ERASE_BUSY = 4'h5,
        DEV_ERASE_DONE = 4'h4, DEV_SUSP_STATUS = 4'hc,
        DEV_SUSP_ARRAY = 4'hd, DEV_STATUS = 4'hf, DEV_ID = 4'he
    } fcsm_dev_type;

    typedef enum logic [1:0] {
        KIND_ARRAY = 2'h0, KIND_STATUS = 2'h1, KIND_ID = 2'h2
    } fcsm_kind_type;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_WLOW = 3'b001, S_WHIGH = 3'b011,
        S_RLOW = 3'b010, S_RDONE = 3'b110
    } fcsm_bus_type;

    typedef struct packed {
        fcsm_op_type op;
        logic [19:0] addr;
        logic [7:0] data;
    } fcsm_req_type;

    typedef struct packed {
        logic [7:0] data;
        fcsm_kind_type kind;
    } fcsm_resp_type;

    typedef struct packed {
        logic [19:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
    } fcsm_pins_type;

    localparam fcsm_pins_type PINS_IDLE = '{addr: 20'h00000,
        dq_out: 8'h00, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
endpackage

//--- fcsm_host.sv
// host controller that sequences commands into the flash command port
`timescale 1ns/1ns
module fcsm_host (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire fcsm_pkg::fcsm_req_type req,
    output fcsm_pkg::fcsm_req_type req_echo_unused,
    output logic req_ready,
    output logic resp_valid,
    output fcsm_pkg::fcsm_resp_type resp,
    output fcsm_pkg::fcsm_dev_type dev_state,
    output logic machine_ready_bit,
    output fcsm_pkg::fcsm_pins_type pins,
    input wire logic [7:0] dq_in
);
    import fcsm_pkg::*;

    // ****************************************************************
    // mirror of the device command state machine
    // ****************************************************************
    function automatic fcsm_dev_type dev_next(fcsm_dev_type cur,
                                              logic [7:0] cmd);
        fcsm_dev_type nxt;
        nxt = DEV_ARRAY;
        unique case (cur)
            DEV_PROG_SETUP: nxt = DEV_PROG_BUSY;
            DEV_PROG_BUSY: nxt = DEV_PROG_BUSY;
            DEV_ERASE_SETUP: begin
                if (cmd == CMD_CONFIRM) begin
                    nxt = DEV_ERASE_BUSY;
                end else begin
                    nxt = DEV_ERASE_ERR;
                end
            end
            DEV_ERASE_BUSY: begin
                if (cmd == CMD_SUSPEND) begin
                    nxt = DEV_SUSP_STATUS;
                end else begin
                    nxt = DEV_ERASE_BUSY;
                end
            end
            DEV_SUSP_STATUS, DEV_SUSP_ARRAY: begin
                // program setup and read id codes leave the suspend state untouched
                if (cmd == CMD_CONFIRM) begin
                    nxt = DEV_ERASE_BUSY;
                end else if (cmd == CMD_READ_STATUS) begin
                    nxt = DEV_SUSP_STATUS;
                end else if (cmd == CMD_PROG_SETUP || cmd == CMD_PROG_ALT
                             || cmd == CMD_READ_ID) begin
                    nxt = cur;
                end else begin
                    nxt = DEV_SUSP_ARRAY;
                end
            end
            default: begin
                // array read, done, error, status and id all decode alike
                if (cmd == CMD_PROG_SETUP || cmd == CMD_PROG_ALT) begin
                    nxt = DEV_PROG_SETUP;
                end else if (cmd == CMD_ERASE_SETUP) begin
                    nxt = DEV_ERASE_SETUP;
                end else if (cmd == CMD_READ_STATUS) begin
                    nxt = DEV_STATUS;
                end else if (cmd == CMD_READ_ID) begin
                    nxt = DEV_ID;
                end else begin
                    nxt = DEV_ARRAY;
                end
            end
        endcase
        return nxt;
    endfunction

    function automatic fcsm_kind_type dev_kind(fcsm_dev_type cur);
        if (cur == DEV_ARRAY || cur == DEV_SUSP_ARRAY) begin
            return KIND_ARRAY;
        end else if (cur == DEV_ID) begin
            return KIND_ID;
        end
        return KIND_STATUS;
    endfunction

    // ****************************************************************
    // three-stage input synchroniser on the data pins
    // ****************************************************************
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
    logic [7:0] dq_s3;
    logic [7:0] dq_stable;

    always_ff @(posedge clk) begin
        dq_s1 <= dq_in;
        dq_s2 <= dq_s1;
        dq_s3 <= dq_s2;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin
                    dq_stable[gi] <= 1'b0;
                end else if (dq_s2[gi] == dq_s3[gi]) begin
                    dq_stable[gi] <= dq_s3[gi];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // bus sequencer
    // ****************************************************************
    fcsm_bus_type bstate;
    fcsm_bus_type next_bstate;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [7:0] second;
    logic [7:0] next_second;
    logic second_pend;
    logic next_second_pend;
    logic polling;
    logic next_polling;
    fcsm_pins_type next_pins;
    fcsm_dev_type next_dev_state;
    logic next_req_ready;
    logic next_resp_valid;
    fcsm_resp_type next_resp;
    logic next_machine_ready_bit;

    always_comb begin
        next_bstate = bstate;
        next_count = count;
        next_second = second;
        next_second_pend = second_pend;
        next_polling = polling;
        next_pins = pins;
        next_dev_state = dev_state;
        next_req_ready = 1'b0;
        next_resp_valid = 1'b0;
        next_resp = resp;
        next_machine_ready_bit = machine_ready_bit;
        unique case (bstate)
            S_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_pins.addr = req.addr;
                    next_pins.ce_n = 1'b0;
                    next_second_pend = 1'b0;
                    next_polling = 1'b0;
                    if (req.op == OP_READ || req.op == OP_POLL) begin
                        // polling keeps reading while status reads show the ready bit clear
                        next_polling = (req.op == OP_POLL);
                        next_pins.oe_n = 1'b0;
                        next_pins.dq_oe = 1'b0;
                        next_count = CNT_W'(READ_CYCLES - 1);
                        next_bstate = S_RLOW;
                    end else begin
                        next_pins.we_n = 1'b0;
                        next_pins.dq_oe = 1'b1;
                        next_count = CNT_W'(WP_CYCLES - 1);
                        next_bstate = S_WLOW;
                        unique case (req.op)
                            OP_PROGRAM: begin
                                next_pins.dq_out = CMD_PROG_SETUP;
                                next_second = req.data;
                                next_second_pend = 1'b1;
                            end
                            OP_ERASE: begin
                                next_pins.dq_out = CMD_ERASE_SETUP;
                                next_second = CMD_CONFIRM;
                                next_second_pend = 1'b1;
                            end
                            OP_SUSPEND: next_pins.dq_out = CMD_SUSPEND;
                            OP_RESUME: next_pins.dq_out = CMD_CONFIRM;
                            OP_READ_STATUS:
                                next_pins.dq_out = CMD_READ_STATUS;
                            OP_CLEAR_STATUS:
                                next_pins.dq_out = CMD_CLEAR_STATUS;
                            OP_READ_ID: next_pins.dq_out = CMD_READ_ID;
                            default: next_pins.dq_out = CMD_READ_ARRAY;
                        endcase
                    end
                end
            end
            S_WLOW: begin
                if (count == '0) begin
                    // the device latches the command on the rising strobe
                    next_pins.we_n = 1'b1;
                    next_pins.ce_n = 1'b1;
                    next_dev_state = dev_next(dev_state, pins.dq_out);
                    if (next_dev_state == DEV_PROG_BUSY
                        || next_dev_state == DEV_ERASE_BUSY) begin
                        next_machine_ready_bit = 1'b0;
                    end else begin
                        next_machine_ready_bit = 1'b1;
                    end
                    next_count = CNT_W'(WPH_CYCLES - 1);
                    next_bstate = S_WHIGH;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            S_WHIGH: begin
                if (count == '0) begin
                    if (second_pend) begin
                        // data byte follows setup with no read between
                        next_second_pend = 1'b0;
                        next_pins.dq_out = second;
                        next_pins.we_n = 1'b0;
                        next_pins.ce_n = 1'b0;
                        next_count = CNT_W'(WP_CYCLES - 1);
                        next_bstate = S_WLOW;
                    end else begin
                        next_pins.dq_oe = 1'b0;
                        next_req_ready = 1'b1;
                        next_bstate = S_IDLE;
                    end
                end else begin
                    next_count = count - 1'b1;
                end
            end
            S_RLOW: begin
                if (count == '0) begin
                    next_pins.oe_n = 1'b1;
                    next_pins.ce_n = 1'b1;
                    next_resp.data = dq_stable;
                    next_resp.kind = dev_kind(dev_state);
                    if (next_resp.kind == KIND_STATUS) begin
                        next_machine_ready_bit = dq_stable[READY_BIT_POS];
                        if (dq_stable[READY_BIT_POS]) begin
                            if (dev_state == DEV_PROG_BUSY) begin
                                next_dev_state = DEV_PROG_DONE;
                            end else if (dev_state == DEV_ERASE_BUSY) begin
                                next_dev_state = DEV_ERASE_DONE;
                            end
                        end
                    end
                    next_count = CNT_W'(WPH_CYCLES - 1);
                    next_bstate = S_RDONE;
                end else begin
                    next_count = count - 1'b1;
                end
            end
            S_RDONE: begin
                if (count == '0) begin
                    if (polling && resp.kind == KIND_STATUS
                        && !resp.data[READY_BIT_POS]) begin
                        next_pins.ce_n = 1'b0;
                        next_pins.oe_n = 1'b0;
                        next_count = CNT_W'(READ_CYCLES - 1);
                        next_bstate = S_RLOW;
                    end else begin
                        next_polling = 1'b0;
                        next_resp_valid = 1'b1;
                        next_req_ready = 1'b1;
                        next_bstate = S_IDLE;
                    end
                end else begin
                    next_count = count - 1'b1;
                end
            end
            default: next_bstate = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bstate <= S_IDLE;
            count <= '0;
            second <= 8'h00;
            second_pend <= 1'b0;
            polling <= 1'b0;
            pins <= PINS_IDLE;
            dev_state <= DEV_ARRAY;
            req_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp <= '{data: 8'h00, kind: KIND_ARRAY};
            machine_ready_bit <= 1'b1;
            req_echo_unused <= '0;
        end else begin
            bstate <= next_bstate;
            count <= next_count;
            second <= next_second;
            second_pend <= next_second_pend;
            polling <= next_polling;
            pins <= next_pins;
            dev_state <= next_dev_state;
            req_ready <= next_req_ready;
            resp_valid <= next_resp_valid;
            resp <= next_resp;
            machine_ready_bit <= next_machine_ready_bit;
            req_echo_unused <= req;
        end
    end
endmodule

//--- fcsm_host_assertions.sv
// concurrent checks on the ports of the flash command sequencer host
`timescale 1ns/1ns
module fcsm_host_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic resp_valid,
    input wire fcsm_pkg::fcsm_resp_type resp,
    input wire fcsm_pkg::fcsm_dev_type dev_state,
    input wire logic machine_ready_bit,
    input wire fcsm_pkg::fcsm_pins_type pins
);
    import fcsm_pkg::*;
    // ****************************************************************
    // state mirror and ready bit
    // ****************************************************************
    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    reset_mode_a: assert property (
        $fell(srst) |-> dev_state == DEV_ARRAY && machine_ready_bit)
        else $error("mirror not in array read after reset");
    busy_low_a: assert property (
        dev_state inside {DEV_PROG_BUSY, DEV_ERASE_BUSY}
        |-> !machine_ready_bit)
        else $error("ready bit high while busy");
    ready_high_a: assert property (
        dev_state inside {DEV_ARRAY, DEV_STATUS, DEV_ID, DEV_PROG_DONE,
            DEV_ERASE_DONE, DEV_SUSP_STATUS, DEV_SUSP_ARRAY}
        |-> machine_ready_bit)
        else $error("ready bit low in an idle state");
    prog_data_a: assert property (
        dev_state == DEV_PROG_SETUP |-> ##[1:12] dev_state == DEV_PROG_BUSY)
        else $error("program data write did not start programming");
    erase_go_a: assert property (
        dev_state == DEV_ERASE_SETUP |-> ##[1:12] dev_state == DEV_ERASE_BUSY)
        else $error("erase confirm did not start erase");
    prog_hold_a: assert property (
        dev_state == DEV_PROG_BUSY
        |=> dev_state inside {DEV_PROG_BUSY, DEV_PROG_DONE})
        else $error("programming left early");
    erase_hold_a: assert property (
        dev_state == DEV_ERASE_BUSY
        |=> dev_state inside {DEV_ERASE_BUSY, DEV_SUSP_STATUS, DEV_ERASE_DONE})
        else $error("erase left by a command other than suspend");
    suspend_go_a: assert property (
        $fell(pins.we_n) && pins.dq_out == 8'hb0 && dev_state == DEV_ERASE_BUSY
        |-> ##[1:10] dev_state == DEV_SUSP_STATUS)
        else $error("suspend not taken during erase");
    susp_stay_a: assert property (
        dev_state inside {DEV_SUSP_STATUS, DEV_SUSP_ARRAY}
        |=> dev_state inside {DEV_SUSP_STATUS, DEV_SUSP_ARRAY, DEV_ERASE_BUSY})
        else $error("suspend state left to a wrong state");
    id_read_a: assert property (
        resp_valid && dev_state == DEV_ID |-> resp.kind == KIND_ID)
        else $error("identifier mode read not tagged as identifier");
    array_read_a: assert property (
        resp_valid && dev_state inside {DEV_ARRAY, DEV_SUSP_ARRAY}
        |-> resp.kind == KIND_ARRAY)
        else $error("array mode read not tagged as array");
endmodule

bind fcsm_host fcsm_host_checker chk (.clk(clk), .srst(srst),
    .resp_valid(resp_valid), .resp(resp), .dev_state(dev_state),
    .machine_ready_bit(machine_ready_bit), .pins(pins));

//--- fcsm_flash_model.sv
// behavioural flash device answering the host's command port
`timescale 1ns/1ns
module fcsm_flash_model #(
    parameter int BUSY_CYCLES = 100,
    parameter logic [7:0] ID_CODE = 8'h3c // arbitrary identifier value
) (
    input wire logic clk,
    input wire fcsm_pkg::fcsm_pins_type pins,
    output logic [7:0] dq_in
);
    import fcsm_pkg::*;
    fcsm_dev_type st = DEV_ARRAY;
    int busy = 0;
    logic we_q = 1'b1;
    logic [7:0] last = 8'h00;
    logic [7:0] rd;
    logic busy_now;

    function automatic fcsm_dev_type nxt(fcsm_dev_type s, logic [7:0] c);
        case (s)
            DEV_PROG_SETUP: return DEV_PROG_BUSY;
            DEV_PROG_BUSY, DEV_ERASE_BUSY: begin
                if (s == DEV_ERASE_BUSY && c == 8'hb0) begin
                    return DEV_SUSP_STATUS;
                end
                return s;
            end
            DEV_ERASE_SETUP: begin
                return (c == 8'hd0) ? DEV_ERASE_BUSY : DEV_ERASE_ERR;
            end
            DEV_SUSP_STATUS, DEV_SUSP_ARRAY: begin
                case (c)
                    8'hd0: return DEV_ERASE_BUSY;
                    8'h70: return DEV_SUSP_STATUS;
                    8'h10, 8'h40, 8'h90: return s;
                    default: return DEV_SUSP_ARRAY;
                endcase
            end
            default: begin
                case (c)
                    8'h10, 8'h40: return DEV_PROG_SETUP;
                    8'h20: return DEV_ERASE_SETUP;
                    8'h70: return DEV_STATUS;
                    8'h90: return DEV_ID;
                    default: return DEV_ARRAY;
                endcase
            end
        endcase
    endfunction

    // ****************************************************************
    // read path: array, status or identifier by state
    // ****************************************************************
    always_comb begin
        busy_now = st inside {DEV_PROG_BUSY, DEV_ERASE_BUSY};
        case (st)
            DEV_ARRAY, DEV_SUSP_ARRAY: begin
                rd = pins.addr[7:0] ^ 8'ha5;
            end
            DEV_ID: rd = ID_CODE;
            default: rd = {~busy_now, 7'h00};
        endcase
        // released bus shows the inverse, so a stale value never passes
        dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~last;
    end

    // ****************************************************************
    // command capture on the write strobe's rising edge
    // ****************************************************************
    always @(posedge clk) begin
        we_q <= pins.we_n;
        if (!pins.ce_n && !pins.oe_n) begin
            last <= rd;
        end
        if (!we_q && pins.we_n) begin
            // undriven data reads as zero, which no confirm step accepts
            st <= nxt(st, pins.dq_oe ? pins.dq_out : 8'h00);
            if (st == DEV_PROG_SETUP || st == DEV_ERASE_SETUP) begin
                busy <= BUSY_CYCLES;
            end
        end else if (busy_now && busy > 0) begin
            busy <= busy - 1;
        end else if (busy_now) begin
            st <= (st == DEV_PROG_BUSY) ? DEV_PROG_DONE : DEV_ERASE_DONE;
        end
    end
endmodule

//--- fcsm_host_test.sv
// self-checking testbench of the flash command sequencer host
`timescale 1ns/1ns
module fcsm_host_test;
    import fcsm_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h3c; // arbitrary identifier value
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    fcsm_req_type req = '0;
    logic req_ready;
    logic resp_valid;
    logic machine_ready_bit;
    fcsm_resp_type resp;
    fcsm_dev_type dev_state;
    fcsm_pins_type pins;
    logic [7:0] dq_in;
    int n_errors = 0;
    int check_count = 0;

    always #4 clk = ~clk;

    fcsm_host uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
        .req_echo_unused(), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp(resp), .dev_state(dev_state),
        .machine_ready_bit(machine_ready_bit), .pins(pins), .dq_in(dq_in));
    fcsm_flash_model #(.BUSY_CYCLES(100), .ID_CODE(ID_VAL)) dev (.clk(clk),
        .pins(pins), .dq_in(dq_in));

    task automatic summarize();
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // request driver and compares
    // ****************************************************************
    task automatic wait_flag(input bit rdy_flag, input int limit);
        int i;
        for (i = 0; i < limit; i++) begin
            if ((rdy_flag ? req_ready : resp_valid) === 1'b1) begin
                break;
            end
            @(posedge clk) #1;
        end
        if (i >= limit) begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic do_op(input fcsm_op_type op, input logic [19:0] a,
        input logic [7:0] d);
        wait_flag(1'b1, 200);
        req_valid = 1'b1;
        req = '{op: op, addr: a, data: d};
        @(posedge clk) #1;
        req_valid = 1'b0;
        if (op == OP_READ || op == OP_POLL) begin
            wait_flag(1'b0, 2000);
        end
        wait_flag(1'b1, 200);
    endtask

    task automatic chk_resp(input logic [7:0] d, input fcsm_kind_type k);
        check_count++;
        if (resp !== {d, k}) begin
            n_errors++;
            $display("unexpected resp at %0t: %h vs %h", $time, resp, {d, k});
        end
    endtask

    task automatic chk_dev(input fcsm_dev_type st, input logic rdy);
        check_count++;
        if ({dev_state, machine_ready_bit} !== {st, rdy}) begin
            n_errors++;
            $display("unexpected state at %0t: %h vs %h", $time,
                {dev_state, machine_ready_bit}, {st, rdy});
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic reset_start();
        chk_dev(DEV_ARRAY, 1'b1);
        do_op(OP_READ, 20'h12345, 8'h00);
        chk_resp(8'h45 ^ 8'ha5, KIND_ARRAY);
    endtask

    task automatic status_modes();
        do_op(OP_READ_STATUS, 20'h00000, 8'h00);
        chk_dev(DEV_STATUS, 1'b1);
        do_op(OP_READ, 20'h00001, 8'h00);
        chk_resp(8'h80, KIND_STATUS);
        do_op(OP_CLEAR_STATUS, 20'h00000, 8'h00);
        chk_dev(DEV_ARRAY, 1'b1);
        do_op(OP_READ_ID, 20'h00000, 8'h00);
        chk_dev(DEV_ID, 1'b1);
        do_op(OP_READ, 20'h00000, 8'h00);
        chk_resp(ID_VAL, KIND_ID);
        do_op(OP_READ_ARRAY, 20'h00000, 8'h00);
        chk_dev(DEV_ARRAY, 1'b1);
        do_op(OP_READ, 20'hfffff, 8'h00);
        chk_resp(8'hff ^ 8'ha5, KIND_ARRAY);
    endtask

    task automatic program_flow();
        // data equal to the read-array code must still be taken as data
        do_op(OP_PROGRAM, 20'h000a0, 8'hff);
        chk_dev(DEV_PROG_BUSY, 1'b0);
        do_op(OP_READ, 20'h000a0, 8'h00);
        chk_resp(8'h00, KIND_STATUS);
        do_op(OP_READ_ARRAY, 20'h00000, 8'h00);
        chk_dev(DEV_PROG_BUSY, 1'b0);
        do_op(OP_POLL, 20'h00000, 8'h00);
        chk_resp(8'h80, KIND_STATUS);
        chk_dev(DEV_PROG_DONE, 1'b1);
        do_op(OP_READ_ID, 20'h00000, 8'h00);
        chk_dev(DEV_ID, 1'b1);
    endtask

    task automatic erase_flow();
        do_op(OP_ERASE, 20'h10000, 8'h00);
        chk_dev(DEV_ERASE_BUSY, 1'b0);
        do_op(OP_READ_STATUS, 20'h00000, 8'h00);
        chk_dev(DEV_ERASE_BUSY, 1'b0);
        do_op(OP_SUSPEND, 20'h00000, 8'h00);
        chk_dev(DEV_SUSP_STATUS, 1'b1);
        do_op(OP_READ, 20'h00000, 8'h00);
        chk_resp(8'h80, KIND_STATUS);
        do_op(OP_READ_ID, 20'h00000, 8'h00);
        chk_dev(DEV_SUSP_STATUS, 1'b1);
        do_op(OP_READ_ARRAY, 20'h00000, 8'h00);
        chk_dev(DEV_SUSP_ARRAY, 1'b1);
        do_op(OP_READ, 20'h00033, 8'h00);
        chk_resp(8'h33 ^ 8'ha5, KIND_ARRAY);
        do_op(OP_READ_STATUS, 20'h00000, 8'h00);
        chk_dev(DEV_SUSP_STATUS, 1'b1);
        do_op(OP_RESUME, 20'h00000, 8'h00);
        chk_dev(DEV_ERASE_BUSY, 1'b0);
        do_op(OP_POLL, 20'h00000, 8'h00);
        chk_dev(DEV_ERASE_DONE, 1'b1);
        do_op(OP_CLEAR_STATUS, 20'h00000, 8'h00);
        chk_dev(DEV_ARRAY, 1'b1);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        @(posedge clk) #1;
        reset_start();
        status_modes();
        program_flow();
        erase_flow();
        summarize();
    end
endmodule
